// [rtl/bil_regs.svh]
// Constants of the boot image loader: timing, codes and image markers.
// Assumes a 25 MHz tile clock; serial rates are given for a 400 MHz core.
`ifndef BIL_REGS_SVH
`define BIL_REGS_SVH
//--------------------------------------------------
// Timing
//--------------------------------------------------
`define BIL_SYS_CLK_KHZ 25000
`define BIL_RST_SEQ_NS 15000
`define BIL_RST_SEQ_CYC ((`BIL_RST_SEQ_NS * `BIL_SYS_CLK_KHZ + 999999) / 1000000)
`define BIL_LINK_EN_NS 2000
`define BIL_LINK_EN_CYC ((`BIL_LINK_EN_NS * `BIL_SYS_CLK_KHZ) / 1000000)
`define BIL_CORE_KHZ 400000
`define BIL_QSPI_KHZ 50000
`define BIL_SPI_KHZ 2500
`define BIL_QSPI_HALF (`BIL_CORE_KHZ / `BIL_QSPI_KHZ / 2)
`define BIL_SPI_HALF (`BIL_CORE_KHZ / `BIL_SPI_KHZ / 2)
`define BIL_LINK_BIT_CYC 3'h4
//--------------------------------------------------
// Codes
//--------------------------------------------------
`define BIL_SEC_BOOT_BIT 5
`define BIL_SEL_QSPI 3'h0
`define BIL_SEL_SPIM 3'h1
`define BIL_SEL_SPIS 3'h2
`define BIL_SEL_SPIS_BOTH 3'h3
`define BIL_SEL_LINK 3'h4
`define BIL_CRC_POLY 32'hEDB8_8320
`define BIL_CRC_INIT 32'hFFFF_FFFF
`define BIL_CRC_SKIP 32'h0D15_AB1E
`define BIL_FLASH_RD_CMD 8'h03
`define BIL_FLASH_ADDR 24'h00_0000
`define BIL_CMD_BITS 6'h20
`define BIL_QBYTE_LAST 3'h1
`define BIL_SBYTE_LAST 3'h7
`define BIL_RAM_BASE 16'h0000
`define BIL_OTP_BASE 11'h000
`define BIL_NULL_CHAN 32'h0000_FF02
`define BIL_END_TOKEN 8'h01
`define BIL_TOK_LAST 4'h8
`endif

// [rtl/bil_pkg.sv]
// Types shared by the boot image loader.
// Assumes the constants of bil_regs.svh.
package bil_pkg;
	typedef enum logic [2:0] {
		SRC_QSPI = 3'h0,
		SRC_SPIM = 3'h1,
		SRC_SPIS = 3'h2,
		SRC_LINK = 3'h3,
		SRC_OTP  = 3'h4
	} bil_src_e;
	typedef enum logic [3:0] {
		ST_RST_SEQ  = 4'h0,
		ST_LINK_DLY = 4'h1,
		ST_ACK_WORD = 4'h2,
		ST_SIZE     = 4'h3,
		ST_PROG     = 4'h4,
		ST_CRC      = 4'h5,
		ST_END_RX   = 4'h6,
		ST_END_TX   = 4'h7,
		ST_RUN      = 4'h8,
		ST_HALT     = 4'h9
	} bil_state_e;
	typedef enum logic [1:0] {
		MS_IDLE = 2'h0,
		MS_CMD  = 2'h1,
		MS_READ = 2'h2
	} bil_mst_e;
	typedef struct packed {
		logic       vld;
		logic [7:0] data;
	} bil_byte_s;
	typedef struct packed {
		logic        we;
		logic [15:0] addr;
		logic [31:0] data;
	} bil_ram_wr_s;
endpackage

// [rtl/bil_loader.sv]
// Boot image loader of one tile: source select, image fetch, CRC, RAM load.
// Assumes RAM and OTP sit on sys_clk; the SPI slave clock is its own domain.
`timescale 1ns/10ps
`include "bil_regs.svh"
module bil_loader
	import bil_pkg::*;
(
	input  wire logic        sys_clk,                   // Tile clock
	input  wire logic        rst_n,                     // Reset; sync on sys_clk, async in the slave
	input  wire logic        boot_select_bit0,          // Strap
	input  wire logic        boot_select_bit1,          // Strap
	input  wire logic        boot_select_bit2,          // Strap
	input  wire logic        tile_id,                   // 0 first tile
	input  wire logic [31:0] security_reg,              // Security word
	output logic             gpio_pulldown_en,          // GPIO pull-downs
	output logic             flash_select_pin_o,        // Flash select
	output logic             flash_select_pin_oe,       // Its enable
	input  wire logic        serial_clock_pin_i,        // Slave clock
	output logic             serial_clock_pin_o,        // Master clock
	output logic             serial_clock_pin_oe,       // Its enable
	input  wire logic        serial_in_or_select_pin_i, // MISO or select_n
	input  wire logic        serial_data_out_pin_i,     // Slave data in
	output logic             serial_data_out_pin_o,     // Master data out
	output logic             serial_data_out_pin_oe,    // Its enable
	input  wire logic [3:0]  quad_data_pins_i,          // Quad data in
	output logic [3:0]       quad_data_pins_o,          // Quad data out
	output logic [3:0]       quad_data_pins_oe,         // Their enables
	output logic             link_pulldown_en,          // Link pull-downs
	input  wire logic [1:0]  link_rx_i,                 // Link receive
	output logic [1:0]       link_tx_o,                 // Link transmit
	output logic             link_tx_oe,                // Its enable
	output logic             otp_rd_en,                 // OTP read pulse
	output logic [10:0]      otp_addr,                  // OTP word address
	input  wire logic [31:0] otp_rdata,                 // Next cycle data
	output bil_ram_wr_s      ram_wr,                    // RAM write port
	output logic             exec_start,                // Jump pulse
	output logic [15:0]      exec_addr,                 // Jump address
	output logic             boot_done,                 // Image accepted
	output logic             boot_error,                // CRC failure
	output bil_src_e         boot_source                // Chosen source
);
	//--------------------------------------------------
	// Declarations
	//--------------------------------------------------
	logic [2:0]  strap_m_r, strap_s_r;
	logic        miso_m_r, miso_s_r;
	logic [3:0]  dq_m_r, dq_s_r;
	logic [1:0]  lrx_m_r, lrx_s_r, lrx_d_r;
	logic        stog_m_r, stog_s_r, stog_d_r;
	bil_state_e  st_r, st_nxt;
	bil_src_e    src_r, src_nxt;
	logic [31:0] cnt_r, cnt_nxt;
	logic [1:0]  bidx_r, bidx_nxt;
	logic [31:0] word_r, word_nxt, size_r, size_nxt;
	logic [31:0] crc_r, crc_nxt, ack_r, ack_nxt, word_in;
	logic        link_en_r, link_en_nxt, pd_r, lpd_r;
	bil_ram_wr_s ram_r, ram_nxt;
	logic        exec_r, exec_nxt, done_r, done_nxt, err_r, err_nxt;
	logic        fetch, fl_go;
	bil_byte_s   in_b;
	bil_mst_e    ms_r, ms_nxt;
	logic [7:0]  hcnt_r, hcnt_nxt, half;
	logic        sclk_r, sclk_nxt, seln_r, seln_nxt;
	logic [5:0]  bitc_r, bitc_nxt;
	logic [31:0] txsh_r, txsh_nxt;
	logic [7:0]  rxsh_r, rxsh_nxt;
	bil_byte_s   mbyte_r, mbyte_nxt;
	logic        sck_oe_r, mosi_oe_r, cs_oe_r, dq0_oe_r;
	logic [1:0]  tgl;
	logic [8:0]  tok_r, tok_nxt, tok_w;
	logic [3:0]  tcnt_r, tcnt_nxt;
	bil_byte_s   lbyte_r, lbyte_nxt;
	logic        lctl_r, lctl_nxt;
	logic [7:0]  lctl_val_r, lctl_val_nxt;
	logic [8:0]  txt_r, txt_nxt;
	logic [3:0]  txc_r, txc_nxt;
	logic [2:0]  txd_r, txd_nxt;
	logic        txb_r, txb_nxt, txok_r, txok_nxt;
	logic [1:0]  ltx_r, ltx_nxt;
	logic        oreq_r, oreq_nxt, owt_r, owt_nxt, ohave_r, ohave_nxt;
	logic [10:0] oaddr_r, oaddr_nxt;
	logic [31:0] oword_r, oword_nxt;
	logic [1:0]  obi_r, obi_nxt;
	bil_byte_s   obyte_r, obyte_nxt;
	logic        slv_clr;
	logic [2:0]  sbit_r;
	logic [7:0]  ssh_r, ssh_nxt, sbyte_r;
	logic        stog_r;

	function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
		logic [31:0] r;
		r = c ^ {24'h00_0000, b};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ `BIL_CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	function automatic bil_src_e pick_src(input logic [2:0] sel, input logic t1, input logic sec);
		bil_src_e s;
		s = SRC_LINK;
		if (sec) begin
			s = SRC_OTP;
		end else if (!t1) begin
			case (sel)
				`BIL_SEL_QSPI:      s = SRC_QSPI;
				`BIL_SEL_SPIM:      s = SRC_SPIM;
				`BIL_SEL_SPIS:      s = SRC_SPIS;
				`BIL_SEL_SPIS_BOTH: s = SRC_SPIS;
				default:            s = SRC_LINK;
			endcase
		end else if (sel == `BIL_SEL_SPIS_BOTH) begin
			s = SRC_SPIS;
		end
		return s;
	endfunction

	//--------------------------------------------------
	// Synchronisers for pins and the slave byte toggle
	//--------------------------------------------------
	always_ff @(posedge sys_clk) begin
		strap_m_r <= {boot_select_bit2, boot_select_bit1, boot_select_bit0};
		strap_s_r <= strap_m_r;
		miso_m_r  <= serial_in_or_select_pin_i;
		miso_s_r  <= miso_m_r;
		dq_m_r    <= quad_data_pins_i;
		dq_s_r    <= dq_m_r;
		lrx_m_r   <= link_rx_i;
		lrx_s_r   <= lrx_m_r;
		lrx_d_r   <= lrx_s_r;
		stog_m_r  <= stog_r;
		stog_s_r  <= stog_m_r;
		stog_d_r  <= stog_s_r;
	end

	//--------------------------------------------------
	// Boot sequence and image parser
	//--------------------------------------------------
	assign fetch = (st_r == ST_ACK_WORD) || (st_r == ST_SIZE) ||
		(st_r == ST_PROG) || (st_r == ST_CRC);

	always_comb begin
		in_b = '0;
		case (src_r)
			SRC_QSPI: in_b = mbyte_r;
			SRC_SPIM: in_b = mbyte_r;
			SRC_SPIS: in_b = {stog_s_r ^ stog_d_r, sbyte_r};
			SRC_LINK: in_b = lbyte_r;
			SRC_OTP:  in_b = obyte_r;
			default:  in_b = '0;
		endcase
		in_b.vld = in_b.vld & fetch;
	end

	always_comb begin
		st_nxt      = st_r;
		src_nxt     = src_r;
		cnt_nxt     = cnt_r;
		bidx_nxt    = bidx_r;
		word_nxt    = word_r;
		size_nxt    = size_r;
		crc_nxt     = crc_r;
		ack_nxt     = ack_r;
		link_en_nxt = link_en_r;
		ram_nxt     = '0;
		exec_nxt    = 1'b0;
		done_nxt    = done_r;
		err_nxt     = err_r;
		word_in     = {in_b.data, word_r[31:8]};
		if (in_b.vld) begin
			bidx_nxt = bidx_r + 2'h1;
			word_nxt = word_in;
			if (st_r == ST_SIZE || st_r == ST_PROG) begin
				crc_nxt = crc_byte(crc_r, in_b.data);
			end
		end
		case (st_r)
			ST_RST_SEQ: begin
				src_nxt = pick_src(strap_s_r, tile_id, security_reg[`BIL_SEC_BOOT_BIT]);
				cnt_nxt = cnt_r + 32'h1;
				if (cnt_r == 32'(`BIL_RST_SEQ_CYC - 1)) begin
					cnt_nxt = '0;
					st_nxt  = (src_nxt == SRC_LINK) ? ST_LINK_DLY : ST_SIZE;
				end
			end
			ST_LINK_DLY: begin
				cnt_nxt = cnt_r + 32'h1;
				if (cnt_r == 32'(`BIL_LINK_EN_CYC - 1)) begin
					cnt_nxt     = '0;
					link_en_nxt = 1'b1;
					st_nxt      = ST_ACK_WORD;
				end
			end
			ST_ACK_WORD: begin
				if (in_b.vld && bidx_r == 2'h3) begin
					ack_nxt = word_in;
					st_nxt  = ST_SIZE;
				end
			end
			ST_SIZE: begin
				if (in_b.vld && bidx_r == 2'h3) begin
					size_nxt = word_in;
					cnt_nxt  = '0;
					st_nxt   = (word_in == '0) ? ST_CRC : ST_PROG;
				end
			end
			ST_PROG: begin
				if (in_b.vld && bidx_r == 2'h3) begin
					ram_nxt = {1'b1, `BIL_RAM_BASE + cnt_r[15:0], word_in};
					cnt_nxt = cnt_r + 32'h1;
					if (cnt_nxt == size_r) begin
						st_nxt = ST_CRC;
					end
				end
			end
			ST_CRC: begin
				if (in_b.vld && bidx_r == 2'h3) begin
					if (word_in == `BIL_CRC_SKIP || word_in == ~crc_r) begin
						st_nxt   = (src_r == SRC_LINK) ? ST_END_RX : ST_RUN;
						exec_nxt = (src_r != SRC_LINK);
						done_nxt = (src_r != SRC_LINK);
					end else begin
						st_nxt  = ST_HALT;
						err_nxt = 1'b1;
					end
				end
			end
			ST_END_RX: begin
				if (lctl_r && lctl_val_r == `BIL_END_TOKEN) begin
					if (ack_r == `BIL_NULL_CHAN) begin
						st_nxt   = ST_RUN;
						exec_nxt = 1'b1;
						done_nxt = 1'b1;
					end else begin
						st_nxt = ST_END_TX;
					end
				end
			end
			ST_END_TX: begin
				if (txok_r) begin
					st_nxt   = ST_RUN;
					exec_nxt = 1'b1;
					done_nxt = 1'b1;
				end
			end
			ST_RUN:  st_nxt = ST_RUN;
			ST_HALT: st_nxt = ST_HALT;
			default: st_nxt = ST_HALT;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st_r      <= ST_RST_SEQ;
			src_r     <= SRC_LINK;
			cnt_r     <= '0;
			bidx_r    <= '0;
			word_r    <= '0;
			size_r    <= '0;
			crc_r     <= `BIL_CRC_INIT;
			ack_r     <= `BIL_NULL_CHAN;
			link_en_r <= 1'b0;
			pd_r      <= 1'b1;
			lpd_r     <= 1'b1;
			ram_r     <= '0;
			exec_r    <= 1'b0;
			done_r    <= 1'b0;
			err_r     <= 1'b0;
		end else begin
			st_r      <= st_nxt;
			src_r     <= src_nxt;
			cnt_r     <= cnt_nxt;
			bidx_r    <= bidx_nxt;
			word_r    <= word_nxt;
			size_r    <= size_nxt;
			crc_r     <= crc_nxt;
			ack_r     <= ack_nxt;
			link_en_r <= link_en_nxt;
			pd_r      <= 1'b0;
			lpd_r     <= ~link_en_nxt;
			ram_r     <= ram_nxt;
			exec_r    <= exec_nxt;
			done_r    <= done_nxt;
			err_r     <= err_nxt;
		end
	end

	//--------------------------------------------------
	// Flash master, single or quad, mode 0
	//--------------------------------------------------
	// Command and address always go out on one wire; quad only speeds reads
	assign fl_go = (src_r == SRC_QSPI || src_r == SRC_SPIM) &&
		(st_r == ST_SIZE || st_r == ST_PROG || st_r == ST_CRC);
	assign half = (src_r == SRC_QSPI) ? 8'(`BIL_QSPI_HALF - 1) : 8'(`BIL_SPI_HALF - 1);

	always_comb begin
		ms_nxt    = ms_r;
		hcnt_nxt  = hcnt_r;
		sclk_nxt  = sclk_r;
		seln_nxt  = seln_r;
		bitc_nxt  = bitc_r;
		txsh_nxt  = txsh_r;
		rxsh_nxt  = rxsh_r;
		mbyte_nxt = '0;
		case (ms_r)
			MS_IDLE: begin
				if (fl_go) begin
					ms_nxt   = MS_CMD;
					seln_nxt = 1'b0;
					txsh_nxt = {`BIL_FLASH_RD_CMD, `BIL_FLASH_ADDR};
					bitc_nxt = '0;
					hcnt_nxt = '0;
				end
			end
			MS_CMD, MS_READ: begin
				if (!fl_go) begin
					ms_nxt   = MS_IDLE;
					seln_nxt = 1'b1;
					sclk_nxt = 1'b0;
				end else if (hcnt_r == half) begin
					hcnt_nxt = '0;
					sclk_nxt = ~sclk_r;
					if (!sclk_r) begin
						bitc_nxt = bitc_r + 6'h1;
						if (ms_r == MS_READ) begin
							if (src_r == SRC_QSPI) begin
								rxsh_nxt = {dq_s_r, rxsh_r[7:4]};
							end else begin
								rxsh_nxt = {miso_s_r, rxsh_r[7:1]};
							end
							if (bitc_r[2:0] == ((src_r == SRC_QSPI) ?
								`BIL_QBYTE_LAST : `BIL_SBYTE_LAST)) begin
								mbyte_nxt = {1'b1, rxsh_nxt};
								bitc_nxt  = '0;
							end
						end
					end else if (ms_r == MS_CMD) begin
						txsh_nxt = {txsh_r[30:0], 1'b0};
						if (bitc_r == `BIL_CMD_BITS) begin
							ms_nxt   = MS_READ;
							bitc_nxt = '0;
						end
					end
				end else begin
					hcnt_nxt = hcnt_r + 8'h1;
				end
			end
			default: ms_nxt = MS_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ms_r      <= MS_IDLE;
			hcnt_r    <= '0;
			sclk_r    <= 1'b0;
			seln_r    <= 1'b1;
			bitc_r    <= '0;
			txsh_r    <= '0;
			rxsh_r    <= '0;
			mbyte_r   <= '0;
			sck_oe_r  <= 1'b0;
			cs_oe_r   <= 1'b0;
			mosi_oe_r <= 1'b0;
			dq0_oe_r  <= 1'b0;
		end else begin
			ms_r      <= ms_nxt;
			hcnt_r    <= hcnt_nxt;
			sclk_r    <= sclk_nxt;
			seln_r    <= seln_nxt;
			bitc_r    <= bitc_nxt;
			txsh_r    <= txsh_nxt;
			rxsh_r    <= rxsh_nxt;
			mbyte_r   <= mbyte_nxt;
			sck_oe_r  <= ms_nxt != MS_IDLE;
			cs_oe_r   <= ms_nxt != MS_IDLE;
			mosi_oe_r <= (ms_nxt != MS_IDLE) && (src_r == SRC_SPIM);
			dq0_oe_r  <= (ms_nxt == MS_CMD) && (src_r == SRC_QSPI);
		end
	end

	//--------------------------------------------------
	// Link: one transition per bit, wire 1 means a one
	//--------------------------------------------------
	assign tgl   = lrx_s_r ^ lrx_d_r;
	assign tok_w = {tgl[1], tok_r[8:1]};

	always_comb begin
		tok_nxt      = tok_r;
		tcnt_nxt     = tcnt_r;
		lbyte_nxt    = '0;
		lctl_nxt     = 1'b0;
		lctl_val_nxt = lctl_val_r;
		if (link_en_r && (tgl[0] ^ tgl[1])) begin
			tok_nxt  = tok_w;
			tcnt_nxt = tcnt_r + 4'h1;
			if (tcnt_r == `BIL_TOK_LAST) begin
				tcnt_nxt = '0;
				if (tok_w[8]) begin
					lctl_nxt     = 1'b1;
					lctl_val_nxt = tok_w[7:0];
				end else begin
					lbyte_nxt = {1'b1, tok_w[7:0]};
				end
			end
		end
		txt_nxt  = txt_r;
		txc_nxt  = txc_r;
		txd_nxt  = txd_r;
		txb_nxt  = txb_r;
		txok_nxt = txok_r;
		ltx_nxt  = ltx_r;
		if (st_r == ST_END_TX && !txb_r && !txok_r) begin
			txt_nxt = {1'b1, `BIL_END_TOKEN};
			txb_nxt = 1'b1;
			txc_nxt = '0;
			txd_nxt = '0;
		end else if (txb_r) begin
			txd_nxt = txd_r + 3'h1;
			if (txd_r == `BIL_LINK_BIT_CYC - 3'h1) begin
				txd_nxt = '0;
				ltx_nxt[txt_r[0]] = ~ltx_r[txt_r[0]];
				txt_nxt = {1'b0, txt_r[8:1]};
				txc_nxt = txc_r + 4'h1;
				if (txc_r == `BIL_TOK_LAST) begin
					txb_nxt  = 1'b0;
					txok_nxt = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			tok_r      <= '0;
			tcnt_r     <= '0;
			lbyte_r    <= '0;
			lctl_r     <= 1'b0;
			lctl_val_r <= '0;
			txt_r      <= '0;
			txc_r      <= '0;
			txd_r      <= '0;
			txb_r      <= 1'b0;
			txok_r     <= 1'b0;
			ltx_r      <= '0;
		end else begin
			tok_r      <= tok_nxt;
			tcnt_r     <= tcnt_nxt;
			lbyte_r    <= lbyte_nxt;
			lctl_r     <= lctl_nxt;
			lctl_val_r <= lctl_val_nxt;
			txt_r      <= txt_nxt;
			txc_r      <= txc_nxt;
			txd_r      <= txd_nxt;
			txb_r      <= txb_nxt;
			txok_r     <= txok_nxt;
			ltx_r      <= ltx_nxt;
		end
	end

	//--------------------------------------------------
	// OTP reader, one word then four bytes
	//--------------------------------------------------
	always_comb begin
		oreq_nxt  = 1'b0;
		owt_nxt   = oreq_r;
		ohave_nxt = ohave_r;
		oaddr_nxt = oaddr_r;
		oword_nxt = oword_r;
		obi_nxt   = obi_r;
		obyte_nxt = '0;
		if (owt_r) begin
			oword_nxt = otp_rdata;
			ohave_nxt = 1'b1;
			oaddr_nxt = oaddr_r + 11'h1;
		end else if (ohave_r) begin
			obyte_nxt = {1'b1, oword_r[8 * obi_r +: 8]};
			obi_nxt   = obi_r + 2'h1;
			ohave_nxt = obi_r != 2'h3;
		end else if (src_r == SRC_OTP && fetch && !oreq_r) begin
			oreq_nxt = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			oreq_r  <= 1'b0;
			owt_r   <= 1'b0;
			ohave_r <= 1'b0;
			oaddr_r <= `BIL_OTP_BASE;
			oword_r <= '0;
			obi_r   <= '0;
			obyte_r <= '0;
		end else begin
			oreq_r  <= oreq_nxt;
			owt_r   <= owt_nxt;
			ohave_r <= ohave_nxt;
			oaddr_r <= oaddr_nxt;
			oword_r <= oword_nxt;
			obi_r   <= obi_nxt;
			obyte_r <= obyte_nxt;
		end
	end

	//--------------------------------------------------
	// SPI slave on the external clock
	//--------------------------------------------------
	// Both supported modes sample on the rising edge; select high ends a frame
	assign slv_clr = serial_in_or_select_pin_i | ~rst_n;
	assign ssh_nxt = {serial_data_out_pin_i, ssh_r[7:1]};

	always_ff @(posedge serial_clock_pin_i or posedge slv_clr) begin
		if (slv_clr) begin
			sbit_r <= '0;
			ssh_r  <= '0;
		end else begin
			sbit_r <= sbit_r + 3'h1;
			ssh_r  <= ssh_nxt;
		end
	end

	// Byte stays still for eight slave clocks, ample for the toggle to cross
	always_ff @(posedge serial_clock_pin_i or negedge rst_n) begin
		if (!rst_n) begin
			sbyte_r <= '0;
			stog_r  <= 1'b0;
		end else if (sbit_r == `BIL_SBYTE_LAST) begin
			sbyte_r <= ssh_nxt;
			stog_r  <= ~stog_r;
		end
	end

	//--------------------------------------------------
	// Outputs
	//--------------------------------------------------
	assign gpio_pulldown_en       = pd_r;
	assign flash_select_pin_o     = seln_r;
	assign flash_select_pin_oe    = cs_oe_r;
	assign serial_clock_pin_o     = sclk_r;
	assign serial_clock_pin_oe    = sck_oe_r;
	assign serial_data_out_pin_o  = txsh_r[31];
	assign serial_data_out_pin_oe = mosi_oe_r;
	assign quad_data_pins_o       = {3'h0, txsh_r[31]};
	assign quad_data_pins_oe      = {3'h0, dq0_oe_r};
	assign link_pulldown_en       = lpd_r;
	assign link_tx_o              = ltx_r;
	assign link_tx_oe             = link_en_r;
	assign otp_rd_en              = oreq_r;
	assign otp_addr               = oaddr_r;
	assign ram_wr                 = ram_r;
	assign exec_start             = exec_r;
	assign exec_addr              = `BIL_RAM_BASE;
	assign boot_done              = done_r;
	assign boot_error             = err_r;
	assign boot_source            = src_r;
endmodule

// [verification/bil_monitor.sv]
// Port checker of the boot image loader.
// Assumes one sys_clk domain with synchronous active-low reset.
`timescale 1ns/10ps
module bil_monitor
	import bil_pkg::*;
(
	input wire logic        sys_clk, // Clock
	input wire logic        rst_n, // Reset
	input wire logic        gpio_pulldown_en, // Pull-downs
	input wire logic        flash_select_pin_o, // Select
	input wire logic        flash_select_pin_oe, // Its enable
	input wire logic        serial_clock_pin_o, // Master clock
	input wire logic        otp_rd_en, // OTP read
	input wire logic [10:0] otp_addr, // OTP address
	input wire bil_ram_wr_s ram_wr, // RAM write
	input wire logic        exec_start, // Jump
	input wire logic [15:0] exec_addr, // Jump target
	input wire logic        boot_done, // Done
	input wire logic        boot_error, // Error
	input wire bil_src_e    boot_source // Source
);
	logic [15:0] cyc_r, cyc_nxt, wrc_r, wrc_nxt;
	logic        seen_r, seen_nxt;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// Cycles since release, words written, first OTP read seen
	always_comb begin
		cyc_nxt  = rst_n ? cyc_r + {15'h0000, cyc_r != 16'hFFFF} : 16'h0000;
		wrc_nxt  = rst_n ? wrc_r + {15'h0000, ram_wr.we} : 16'h0000;
		seen_nxt = rst_n & (seen_r | otp_rd_en);
	end
	always_ff @(posedge sys_clk) begin
		cyc_r  <= cyc_nxt;
		wrc_r  <= wrc_nxt;
		seen_r <= seen_nxt;
	end
	// ------
	// Assertions
	// ------
	property p_pd; $rose(rst_n) |-> gpio_pulldown_en; endproperty
	a_pd: assert property (p_pd) else $error("pull-downs off in reset");
	property p_start; flash_select_pin_oe && !flash_select_pin_o || otp_rd_en |-> cyc_r >= 16'h0177; endproperty
	a_start: assert property (p_start) else $error("boot before reset sequence");
	property p_otp; otp_rd_en |-> boot_source == SRC_OTP && (seen_r || otp_addr == 11'h000); endproperty
	a_otp: assert property (p_otp) else $error("bad OTP read");
	property p_wr; ram_wr.we |-> ram_wr.addr == wrc_r; endproperty
	a_wr: assert property (p_wr) else $error("RAM address out of order");
	property p_exec; exec_start |-> exec_addr == 16'h0000 && wrc_r != 16'h0000 ##[0:1] boot_done; endproperty
	a_exec: assert property (p_exec) else $error("bad jump");
	property p_halt; boot_error |-> !exec_start && !boot_done ##1 boot_error; endproperty
	a_halt: assert property (p_halt) else $error("error state left");
	property p_sel; $fell(flash_select_pin_o) |-> !serial_clock_pin_o; endproperty
	a_sel: assert property (p_sel) else $error("clock high at select");
	property p_qhalf;
		boot_source == SRC_QSPI && $rose(serial_clock_pin_o) |=>
			(serial_clock_pin_o[*3] ##1 !serial_clock_pin_o) or (##[0:2] flash_select_pin_o);
	endproperty
	a_qhalf: assert property (p_qhalf) else $error("quad clock rate");
	c_run: cover property (exec_start);
	c_err: cover property ($rose(boot_error));
	c_otp: cover property (otp_rd_en);
endmodule
bind bil_loader bil_monitor u_mon (.*);

// [verification/bil_flash_model.sv]
// Serial flash partner: after 32 command clocks it streams the image.
// Assumes mode 0; the command is only recorded, not decoded.
`timescale 1ns/10ps
module bil_flash_model (
	input  wire logic         sel_n, // Select, active low
	input  wire logic         sclk, // Clock
	input  wire logic         mosi, // Command in
	input  wire logic [127:0] img, // Image, first byte low
	output logic              miso, // Single data
	output logic [3:0]        dq, // Quad data
	output logic [31:0]       cmd // First 32 bits of a frame
);
	int n = 0;
	initial {miso, dq} = 5'h00;
	always @(posedge sclk or posedge sel_n) begin
		if (!sel_n && n < 32)
			cmd = {cmd[30:0], mosi};
		n = sel_n ? 0 : n + 1;
	end
	// Released lines flip so a stale bit never passes as data
	always @(negedge sclk or posedge sel_n)
		if (sel_n)
			{miso, dq} <= ~{miso, dq};
		else if (n >= 32)
			{miso, dq} <= {img[n - 32], img[4 * (n - 32) +: 4]};
endmodule

// [verification/bil_loader_tb.sv]
// Bench of the boot image loader: straps, OTP, quad and single flash, SPI slave.
// Assumes bil_flash_model and the bound bil_monitor are compiled first.
`timescale 1ns/10ps
module bil_loader_tb;
	import bil_pkg::*;
	logic         sys_clk = 1'b0, rst_n = 1'b0, tile = 1'b0, slave = 1'b0;
	logic         sck = 1'b0, ss_n = 1'b1, mosi = 1'b0;
	logic         miso, fsel, fsel_oe, sclk_o, sclk_oe, gpd, otp_en, exs, done, err;
	logic [2:0]   sel = 3'h0;
	logic [3:0]   dq, qo;
	logic [10:0]  otp_a;
	logic [31:0]  sec = 32'h0000_0000, otp_q = 32'h0000_0000, fcmd;
	logic [127:0] img = 128'h0;
	logic [1:0]   lrx = 2'h0, ltx;
	logic         lpd, ltxoe, so, so_oe;
	bil_ram_wr_s  ram;
	bil_src_e     src;
	int           miscompares = 0, checks = 0, nwr = 0, nex = 0;
	bil_loader uut (.sys_clk(sys_clk), .rst_n(rst_n), .boot_select_bit0(sel[0]),
		.boot_select_bit1(sel[1]), .boot_select_bit2(sel[2]), .tile_id(tile),
		.security_reg(sec), .gpio_pulldown_en(gpd), .flash_select_pin_o(fsel),
		.flash_select_pin_oe(fsel_oe), .serial_clock_pin_i(sclk_oe ? sclk_o : sck),
		.serial_clock_pin_o(sclk_o), .serial_clock_pin_oe(sclk_oe),
		.serial_in_or_select_pin_i(slave ? ss_n : miso), .serial_data_out_pin_i(mosi),
		.serial_data_out_pin_o(so), .serial_data_out_pin_oe(so_oe), .quad_data_pins_i(dq),
		.quad_data_pins_o(qo), .quad_data_pins_oe(), .link_pulldown_en(lpd),
		.link_rx_i(lrx), .link_tx_o(ltx), .link_tx_oe(ltxoe),
		.otp_rd_en(otp_en), .otp_addr(otp_a), .otp_rdata(otp_q), .ram_wr(ram),
		.exec_start(exs), .exec_addr(), .boot_done(done), .boot_error(err),
		.boot_source(src));
	bil_flash_model fm (.sel_n(fsel | !fsel_oe), .sclk(sclk_o), .mosi(so_oe ? so : qo[0]),
		.img(img), .miso(miso), .dq(dq), .cmd(fcmd));
	initial
		forever #20 sys_clk = ~sys_clk;
	initial begin
		#2_000_000;
		miscompares++;
		test_done;
	end
	task automatic test_done;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(logic [31:0] a, logic [31:0] e);
		checks++;
		if (a !== e) begin
			miscompares++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, a, e);
		end
	endtask
	// Two-word image; cm 0 good CRC, 1 skip code, 2 corrupted CRC
	function automatic logic [127:0] mk(logic [1:0] cm);
		logic [95:0] b;
		logic [31:0] c;
		b = {32'h9ABC_DEF0, 32'h1234_5678, 32'h0000_0002};
		c = 32'hFFFF_FFFF;
		for (int i = 0; i < 96; i++)
			c = (c >> 1) ^ ((c[0] ^ b[i]) ? 32'hEDB8_8320 : 32'h0000_0000);
		return {(cm == 2'h1) ? 32'h0D15_AB1E : ~c ^ {31'h0000_0000, cm[1]}, b};
	endfunction
	always @(posedge sys_clk)
		otp_q <= otp_en ? img[32 * otp_a +: 32] : ~otp_q;
	always @(posedge sys_clk) begin
		if (ram.we === 1'b1) begin
			chk({16'h0000, ram.addr}, nwr);
			chk(ram.data, img[32 * nwr + 32 +: 32]);
			nwr++;
		end
		if (exs === 1'b1)
			nex++;
	end
	task automatic boot(logic [2:0] s, logic t, logic sc, logic [1:0] cm);
		@(posedge sys_clk);
		rst_n <= 1'b0;
		sel <= s;
		tile <= t;
		sec <= {26'h000_0000, sc, 5'h00};
		img <= mk(cm);
		repeat (8) @(posedge sys_clk);
		chk(gpd, 1'b1);
		rst_n <= 1'b1;
		nwr = 0;
		nex = 0;
	endtask
	task automatic fin(logic ok, bil_src_e es);
		int n;
		n = 0;
		while (done !== 1'b1 && err !== 1'b1 && n < 30000) begin
			@(posedge sys_clk);
			n++;
		end
		repeat (2) @(posedge sys_clk);
		chk(done, ok);
		chk(err, !ok);
		chk(nex, ok);
		chk(nwr, 32'h2);
		chk(src, es);
		$display("test end: source %0d", es);
	endtask
	// Link token, LSB first; a toggle on wire 1 is a one, on wire 0 a zero
	task automatic ltok(logic [8:0] t);
		for (int i = 0; i < 9; i++) begin
			repeat (4) @(posedge sys_clk);
			lrx <= lrx ^ {t[i], !t[i]};
		end
	endtask
	// Slave byte, LSB first; p is the idle clock level, so mode 0/0 or 1/1
	task automatic sbyte(logic [7:0] d, logic p);
		#13 sck = p;
		#40 ss_n = 1'b0;
		for (int i = 0; i < 8; i++) begin
			#40 sck = 1'b0;
			mosi = d[i];
			#40 sck = 1'b1;
		end
		#40 sck = p;
		#40 ss_n = 1'b1;
		mosi = ~mosi;
	endtask
	// ------
	// Tests
	// ------
	initial begin
		for (int t = 0; t < 2; t++) begin
			for (int s = 0; s < 5; s++) begin
				boot(s[2:0], t[0], 1'b0, 2'h0);
				repeat (440) @(posedge sys_clk);
				chk(src, (s == 4 || t && s < 3) ? SRC_LINK : (s > 1) ? SRC_SPIS : s);
			end
		end
		$display("test end: strap table");
		boot(3'h0, 1'b0, 1'b1, 2'h1);
		fin(1'b1, SRC_OTP);
		boot(3'h1, 1'b0, 1'b1, 2'h2);
		fin(1'b0, SRC_OTP);
		boot(3'h0, 1'b0, 1'b0, 2'h0);
		fin(1'b1, SRC_QSPI);
		chk(fcmd, 32'h0300_0000);
		boot(3'h1, 1'b0, 1'b0, 2'h0);
		fin(1'b1, SRC_SPIM);
		chk(fcmd, 32'h0300_0000);
		for (int a = 0; a < 2; a++) begin
			boot(3'h4, 1'b0, 1'b0, 2'h0);
			lrx <= 2'h0;
			repeat (440) @(posedge sys_clk);
			for (int i = 0; i < 20; i++)
				ltok({1'b0, 8'({img, a ? 32'h0000_FF02 : 32'h0000_0003} >> 8 * i)});
			ltok(9'h101);
			fin(1'b1, SRC_LINK);
			chk({lpd, ltxoe, ltx}, {2'h1, a ? 2'h0 : 2'h1});
		end
		slave <= 1'b1;
		boot(3'h2, 1'b0, 1'b0, 2'h0);
		repeat (400) @(posedge sys_clk);
		for (int i = 0; i < 16; i++)
			sbyte(img[8 * i +: 8], i[0]);
		fin(1'b1, SRC_SPIS);
		test_done;
	end
endmodule
